// *** verilog/irv_pkg.sv ***
// Package of constants and carrier types for the interrupt request and vectoring block.
package irv_pkg;
  // ---------------------------------------------------------------
  // Sizes and fixed values
  // ---------------------------------------------------------------
  localparam int          NUM_SRC       = 8;
  localparam int          SRC_W         = 3;
  localparam int          VEC_W         = 8;
  localparam int          ADDR_W        = 28;
  localparam int          VEC_SLOT_BYTES = 4;
  localparam logic [7:0]  SWI_ISP_LIMIT = 8'h7F;
  localparam logic [27:0] BRK_CHECK_ADDR = 28'hFFF_FFE7;
  localparam logic [7:0]  BRK_ERASED    = 8'hFF;
  localparam logic [7:0]  BRK_FIXED_VEC = 8'h00;
  localparam logic [7:0]  PERIPH_VEC_BASE = 8'h10;
  localparam logic [7:0]  WDT_VEC       = 8'h08;
  localparam logic [27:0] FIXED_BRK_SLOT = 28'hFFF_FFE4;

  typedef enum logic [4:0] {
    IRV_IDLE  = 5'b0_0001,
    IRV_CHECK = 5'b0_0010,
    IRV_FETCH = 5'b0_0100,
    IRV_JUMP  = 5'b0_1000,
    IRV_RUN   = 5'b1_0000
  } irv_state_t;

  typedef struct packed {
    logic              valid;
    logic [VEC_W-1:0]  vecNum;
    logic              isSoft;
  } irv_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } irv_fetch_t;
endpackage : irv_pkg

// *** verilog/irv_pending.sv ***
// Per-source request-pending flags with priority pick.
`timescale 1ns/10ps
`default_nettype none
module irv_pending (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         clkEn,
  input  wire logic [irv_pkg::NUM_SRC-1:0]  srcReq,
  input  wire logic [irv_pkg::NUM_SRC-1:0]  swClr,
  input  wire logic [irv_pkg::NUM_SRC-1:0]  ackClr,
  output logic      [irv_pkg::NUM_SRC-1:0]  pending,
  output logic                              anyPending,
  output logic      [irv_pkg::SRC_W-1:0]    topSrc
);
  import irv_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] flag;
  } irv_pend_st_t;

  irv_pend_st_t st;
  irv_pend_st_t next_st;

  // A new request wins over either clear in the same cycle.
  always_comb begin
    next_st.flag = (st.flag & ~swClr & ~ackClr) | srcReq;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign pending    = st.flag;
  assign anyPending = |st.flag;

  always_comb begin
    topSrc = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (st.flag[i]) begin
        topSrc = SRC_W'(i);
      end
    end
  end

  a_pend_hold : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.flag[0] && !swClr[0] && !ackClr[0] |=> st.flag[0])
    else $error("pending flag dropped without clear");
  a_pend_clear : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && |(ackClr & ~srcReq) |=> (st.flag & $past(ackClr & ~srcReq)) == '0)
    else $error("pending flag not cleared on accept");
endmodule : irv_pending
`default_nettype wire

// *** verilog/irv_core.sv ***
// Interrupt request latching, stack select and vector fetch sequencer.
// Contract
// - Software interrupts 0-127 save stack-select flag then clear it, using interrupt stack.
// - Return from handler restores stack-select flag to the saved value.
// - Software interrupts 128-255 leave the active stack pointer unchanged.
// - Each vector occupies a 4-byte slot holding the handler start address.
// - On accept, fetch the slot's address and continue execution there.
// - Break with all-ones check byte vectors through software interrupt 0 slot.
// - Pending flag sets on request and holds until accepted or cleared by software (swClr).
// - Pending flag clears when the request is accepted and the jump occurs.
// - Watchdog underflow gives interrupt or reset; reset choice is sticky until reset.
`timescale 1ns/10ps
`default_nettype none
module irv_core (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         clkEn,
  input  wire logic [irv_pkg::NUM_SRC-2:0]  periphReq,
  input  wire logic [irv_pkg::NUM_SRC-1:0]  swClr,
  input  wire logic                         wdtUnderflow,
  input  wire logic                         wdtActionWr,
  input  wire logic                         wdtActionData,
  input  wire irv_pkg::irv_req_t            softReq,
  input  wire logic                         breakTrap,
  input  wire logic                         cpuAccept,
  input  wire logic                         cpuReti,
  input  wire logic                         stackSelIn,
  input  wire logic [irv_pkg::ADDR_W-1:0]   vecTableBase,
  input  wire logic                         memValid,
  input  wire logic [31:0]                  memData,
  output irv_pkg::irv_fetch_t               memReq,
  output logic                              intLine,
  output logic [irv_pkg::VEC_W-1:0]         intVec,
  output logic                              stackSel,
  output logic                              jumpValid,
  output logic [irv_pkg::ADDR_W-1:0]        jumpAddr,
  output logic                              wdtResetReq,
  output logic                              wdtActionSel,
  output logic [irv_pkg::NUM_SRC-1:0]       pendingOut
);
  import irv_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    irv_state_t          fsm;
    logic                uFlag;
    logic                uSaved;
    logic                stkChanged;
    logic                wdtSel;
    logic                wdtRst;
    logic [VEC_W-1:0]    vec;
    logic                fromSoft;
    logic [SRC_W-1:0]    src;
    logic                lineOut;
    logic [VEC_W-1:0]    vecOut;
    irv_fetch_t          mem;
    logic                jmp;
    logic [ADDR_W-1:0]   jAddr;
    logic [NUM_SRC-1:0]  pendOut;
  } irv_core_st_t;

  irv_core_st_t st;
  irv_core_st_t next_st;

  logic [NUM_SRC-1:0] srcReq;
  logic [NUM_SRC-1:0] ackClr;
  logic [NUM_SRC-1:0] pending;
  logic               anyPending;
  logic [SRC_W-1:0]   topSrc;

  function automatic logic [ADDR_W-1:0] slotAddr(input logic [ADDR_W-1:0] base,
                                                 input logic [VEC_W-1:0] v);
    slotAddr = base + ADDR_W'({v, 2'b00});
  endfunction : slotAddr

  function automatic logic [VEC_W-1:0] srcVec(input logic [SRC_W-1:0] s);
    srcVec = (s == '0) ? WDT_VEC : PERIPH_VEC_BASE + VEC_W'(s);
  endfunction : srcVec

  // Source 0 is the watchdog; it only requests when the interrupt action is chosen.
  assign srcReq = {periphReq, wdtUnderflow & ~st.wdtSel};

  irv_pending u_pending (
    .clk        (clk),
    .arst_n     (arst_n),
    .clkEn      (clkEn),
    .srcReq     (srcReq),
    .swClr      (swClr),
    .ackClr     (ackClr),
    .pending    (pending),
    .anyPending (anyPending),
    .topSrc     (topSrc)
  );

  // Clear is driven in the cycle that the jump is issued; the flag drops at the next edge.
  always_comb begin
    ackClr = '0;
    if (st.fsm == IRV_JUMP && !st.fromSoft) begin
      ackClr[st.src] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.jmp     = 1'b0;
    next_st.wdtRst  = 1'b0;
    next_st.pendOut = pending;
    next_st.lineOut = anyPending && st.fsm == IRV_IDLE;
    next_st.vecOut  = srcVec(topSrc);
    // While a handler owns the interrupt stack, the flag is held until its return.
    if ((st.fsm == IRV_IDLE || st.fsm == IRV_RUN) && !st.stkChanged) begin
      next_st.uFlag = stackSelIn;
    end
    // Once set, the reset choice can only be cleared by reset.
    if (wdtActionWr && wdtActionData) begin
      next_st.wdtSel = 1'b1;
    end
    if (wdtUnderflow && st.wdtSel) begin
      next_st.wdtRst = 1'b1;
    end
    case (st.fsm)
      IRV_IDLE, IRV_RUN: begin
        if (cpuReti && st.stkChanged) begin
          next_st.uFlag      = st.uSaved;
          next_st.stkChanged = 1'b0;
        end else if (breakTrap) begin
          next_st.fromSoft  = 1'b1;
          next_st.vec       = BRK_FIXED_VEC;
          next_st.mem.valid = 1'b1;
          next_st.mem.addr  = BRK_CHECK_ADDR;
          next_st.fsm       = IRV_CHECK;
        end else if (softReq.valid) begin
          next_st.fromSoft = 1'b1;
          next_st.vec      = softReq.vecNum;
          if (softReq.vecNum <= SWI_ISP_LIMIT) begin
            next_st.uSaved     = stackSelIn;
            next_st.uFlag      = 1'b0;
            next_st.stkChanged = 1'b1;
          end
          next_st.mem.valid = 1'b1;
          next_st.mem.addr  = slotAddr(vecTableBase, softReq.vecNum);
          next_st.fsm       = IRV_FETCH;
        end else if (cpuAccept && anyPending && st.fsm == IRV_IDLE) begin
          next_st.fromSoft   = 1'b0;
          next_st.src        = topSrc;
          next_st.vec        = srcVec(topSrc);
          next_st.uSaved     = stackSelIn;
          next_st.uFlag      = 1'b0;
          next_st.stkChanged = 1'b1;
          next_st.mem.valid  = 1'b1;
          next_st.mem.addr   = slotAddr(vecTableBase, srcVec(topSrc));
          next_st.fsm        = IRV_FETCH;
        end
      end
      IRV_CHECK: begin
        if (memValid) begin
          // Erased check byte selects the relocatable table entry.
          next_st.mem.addr = (memData[7:0] == BRK_ERASED) ?
                             slotAddr(vecTableBase, BRK_FIXED_VEC) : FIXED_BRK_SLOT;
          next_st.uSaved     = st.uFlag;
          next_st.uFlag      = 1'b0;
          next_st.stkChanged = 1'b1;
          next_st.fsm        = IRV_FETCH;
        end
      end
      IRV_FETCH: begin
        if (memValid) begin
          next_st.mem.valid = 1'b0;
          next_st.jAddr     = memData[ADDR_W-1:0];
          next_st.jmp       = 1'b1;
          next_st.fsm       = IRV_JUMP;
        end
      end
      IRV_JUMP: begin
        next_st.fsm = IRV_RUN;
      end
      default: begin
        next_st.fsm = IRV_IDLE;
      end
    endcase
    // A request taken in the run cycle keeps the state that it chose.
    if (st.fsm == IRV_RUN && next_st.fsm == IRV_RUN) begin
      next_st.fsm = IRV_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st     <= '0;
      st.fsm <= IRV_IDLE;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign memReq       = st.mem;
  assign intLine      = st.lineOut;
  assign intVec       = st.vecOut;
  assign stackSel     = st.uFlag;
  assign jumpValid    = st.jmp;
  assign jumpAddr     = st.jAddr;
  assign wdtResetReq  = st.wdtRst;
  assign wdtActionSel = st.wdtSel;
  assign pendingOut   = st.pendOut;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_low_swi_isp : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.fsm == IRV_IDLE && !cpuReti && !breakTrap && softReq.valid
    && softReq.vecNum <= SWI_ISP_LIMIT |=> !st.uFlag && st.uSaved == $past(stackSelIn))
    else $error("low soft interrupt did not select interrupt stack");
  a_high_swi_keep : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.fsm == IRV_IDLE && !cpuReti && !breakTrap && softReq.valid
    && softReq.vecNum > SWI_ISP_LIMIT && !st.stkChanged |=> st.uFlag == $past(stackSelIn))
    else $error("high soft interrupt changed stack");
  a_reti_restore : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && cpuReti && st.stkChanged && (st.fsm == IRV_IDLE || st.fsm == IRV_RUN)
    |=> st.uFlag == $past(st.uSaved))
    else $error("stack flag not restored on return");
  a_slot_addr : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.fsm == IRV_IDLE && !cpuReti && !breakTrap && softReq.valid
    |=> st.mem.addr == $past(vecTableBase) + ADDR_W'({$past(softReq.vecNum), 2'b00}))
    else $error("vector slot address wrong");
  a_fetch_jump : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.fsm == IRV_FETCH && memValid
    |=> st.jmp && st.jAddr == $past(memData[ADDR_W-1:0]))
    else $error("jump not taken to fetched address");
  a_brk_erased : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && st.fsm == IRV_CHECK && memValid && memData[7:0] == BRK_ERASED
    |=> st.mem.addr == $past(vecTableBase))
    else $error("break did not use soft interrupt 0 slot");
  a_wdt_sticky : assert property (@(posedge clk) disable iff (!arst_n)
    st.wdtSel |=> st.wdtSel)
    else $error("watchdog reset choice cleared");
  a_wdt_reset : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && wdtUnderflow && st.wdtSel |-> !srcReq[0] ##1 wdtResetReq)
    else $error("watchdog underflow did not request reset");
  a_line_vec : assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && anyPending && st.fsm == IRV_IDLE |=> intLine && intVec == srcVec($past(topSrc)))
    else $error("request line or vector wrong");
endmodule : irv_core
`default_nettype wire

// *** dv/irv_mem_model.sv ***
// Memory model that answers vector and check-byte reads from the sequencer.
`timescale 1ns/10ps
`default_nettype none
module irv_mem_model (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire irv_pkg::irv_fetch_t memReq,
  input  wire logic [3:0]          waitCycles,
  input  wire logic [7:0]          checkByte,
  output logic                     memValid,
  output logic [31:0]              memData
);
  import irv_pkg::*;
  logic [3:0] cnt;
  // Data is inverted once the answer is gone so a stale value cannot pass.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memValid <= 1'b0;
      memData  <= 32'h0000_0000;
      cnt      <= 4'h0;
    end else if (memValid) begin
      memValid <= 1'b0;
      memData  <= ~memData;
      cnt      <= 4'h0;
    end else if (memReq.valid && cnt < waitCycles) begin
      cnt <= cnt + 4'h1;
    end else if (memReq.valid) begin
      memValid <= 1'b1;
      if (memReq.addr == BRK_CHECK_ADDR) begin
        memData <= {4{checkByte}};
      end else begin
        memData <= {4'h0, memReq.addr ^ 28'h5A5_0000};
      end
    end
  end
endmodule : irv_mem_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench of the interrupt request and vectoring block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import irv_pkg::*;
  logic clk = 0, arst_n = 0, clkEn = 1, wdtUnderflow = 0, wdtActionWr = 0, wdtActionData = 0;
  logic breakTrap = 0, cpuAccept = 0, cpuReti = 0, stackSelIn = 1, memValid;
  logic intLine, stackSel, jumpValid, wdtResetReq, wdtActionSel;
  logic [6:0]  periphReq = 0;
  logic [7:0]  swClr = 0, intVec, pendingOut, checkByte = 8'hFF;
  logic [3:0]  waitCycles = 0;
  logic [27:0] vecBase = 28'h010_0000, jumpAddr, got;
  logic [31:0] memData;
  logic [27:0] seen[$];
  irv_req_t    softReq = '0;
  irv_fetch_t  memReq;
  int error_cnt = 0, check_count = 0;

  always #12.5 clk = ~clk;

  irv_core DUT (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .periphReq(periphReq),
    .swClr(swClr), .wdtUnderflow(wdtUnderflow), .wdtActionWr(wdtActionWr),
    .wdtActionData(wdtActionData), .softReq(softReq), .breakTrap(breakTrap),
    .cpuAccept(cpuAccept), .cpuReti(cpuReti), .stackSelIn(stackSelIn),
    .vecTableBase(vecBase), .memValid(memValid), .memData(memData), .memReq(memReq),
    .intLine(intLine), .intVec(intVec), .stackSel(stackSel), .jumpValid(jumpValid),
    .jumpAddr(jumpAddr), .wdtResetReq(wdtResetReq), .wdtActionSel(wdtActionSel),
    .pendingOut(pendingOut));

  irv_mem_model MEM (.clk(clk), .arst_n(arst_n), .memReq(memReq), .waitCycles(waitCycles),
    .checkByte(checkByte), .memValid(memValid), .memData(memData));

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic g, input logic e);
    cmp_val({31'h0, g}, {31'h0, e});
  endtask : cmp_flag

  function automatic logic [27:0] slot_of(input logic [7:0] v);
    return vecBase + {18'h0, v, 2'b00};
  endfunction : slot_of

  // Records each read address that differs from the last one recorded until the jump pulse, then idles two cycles.
  task automatic wait_jump();
    int n;
    n = 0;
    seen.delete();
    while (jumpValid !== 1'b1 && n < 40) begin
      @(negedge clk);
      if (memReq.valid === 1'b1 && (seen.size() == 0 || seen[$] !== memReq.addr))
        seen.push_back(memReq.addr);
      n++;
    end
    cmp_flag(jumpValid, 1'b1);
    got = jumpAddr;
    repeat (2) @(negedge clk);
  endtask : wait_jump

  task automatic t_soft_low();
    softReq = '{1'b1, 8'd127, 1'b1};
    @(negedge clk);
    softReq = '0;
    wait_jump();
    cmp_val(seen[0], slot_of(8'd127));
    cmp_val(got, slot_of(8'd127) ^ 28'h5A5_0000);
    cmp_flag(stackSel, 1'b0);
    stackSelIn = 0;
    cpuReti = 1;
    @(negedge clk);
    cpuReti = 0;
    stackSelIn = 1;
    cmp_flag(stackSel, 1'b1);
    repeat (2) @(negedge clk);
    cmp_flag(stackSel, 1'b1);
  endtask : t_soft_low

  task automatic t_soft_high();
    for (int i = 0; i < 2; i++) begin
      softReq = '{1'b1, (i == 0) ? 8'd128 : 8'd255, 1'b1};
      @(negedge clk);
      softReq = '0;
      cmp_flag(stackSel, 1'b1);
      wait_jump();
      cmp_flag(stackSel, 1'b1);
    end
  endtask : t_soft_high

  task automatic t_break(input logic [7:0] b, input logic [27:0] slot);
    checkByte = b;
    breakTrap = 1;
    @(negedge clk);
    breakTrap = 0;
    wait_jump();
    cmp_val(seen[0], BRK_CHECK_ADDR);
    cmp_val(seen[1], slot);
    cmp_val(got, slot ^ 28'h5A5_0000);
  endtask : t_break

  task automatic t_periph();
    waitCycles = 3;
    periphReq = 7'h05;
    @(negedge clk);
    periphReq = 0;
    repeat (4) @(negedge clk);
    cmp_val(pendingOut, 8'h0A);
    swClr = 8'h02;
    @(negedge clk);
    swClr = 0;
    repeat (2) @(negedge clk);
    cmp_val(pendingOut, 8'h08);
    cmp_flag(intLine, 1'b1);
    cmp_val(intVec, PERIPH_VEC_BASE + 8'h03);
    cpuAccept = 1;
    @(negedge clk);
    cpuAccept = 0;
    wait_jump();
    cmp_val(got, slot_of(8'h13) ^ 28'h5A5_0000);
    cmp_val(pendingOut, 8'h00);
    waitCycles = 0;
  endtask : t_periph

  task automatic t_wdt();
    wdtUnderflow = 1;
    @(negedge clk);
    wdtUnderflow = 0;
    repeat (2) @(negedge clk);
    cmp_val(pendingOut, 8'h01);
    cmp_val(intVec, WDT_VEC);
    cmp_flag(wdtResetReq, 1'b0);
    swClr = 8'h01;
    @(negedge clk);
    swClr = 0;
    for (int i = 0; i < 3; i++) begin
      wdtActionWr = 1;
      wdtActionData = (i == 1);
      @(negedge clk);
      wdtActionWr = 0;
      @(negedge clk);
      cmp_flag(wdtActionSel, i != 0);
    end
    wdtUnderflow = 1;
    @(negedge clk);
    wdtUnderflow = 0;
    cmp_flag(wdtResetReq, 1'b1);
    repeat (2) @(negedge clk);
    cmp_flag(wdtResetReq, 1'b0);
    cmp_val(pendingOut, 8'h00);
    clkEn = 0;
    wdtUnderflow = 1;
    @(negedge clk);
    wdtUnderflow = 0;
    clkEn = 1;
    @(negedge clk);
    cmp_flag(wdtResetReq, 1'b0);
  endtask : t_wdt

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    t_soft_low();
    t_soft_high();
    t_break(8'hFF, slot_of(BRK_FIXED_VEC));
    t_break(8'h00, FIXED_BRK_SLOT);
    t_periph();
    t_wdt();
    report_and_stop();
  end

  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
